//--- hdl/cps_core.sv
// Notes on behaviour
// - The indirect data port stores nothing and every access to it reaches the data location named by the RAM select pointer.
// - The timer count increments by one per selected edge of the counter pin or per system clock cycle, as configured.
// - The timer count is written and read like any plain data register.
// - The program counter addresses a 4K-word program store of 13-bit codes, one code per address.
// - A direct jump loads the low 10 counter bits from the operation's address field.
// - A subroutine invoke pushes the next address onto the stack and loads the low 10 counter bits.
// - Subroutine exit, exit with literal and interrupt exit reload the whole counter from the stack top.
// - Load-counter-from-accumulator copies the accumulator into the counter but keeps its ninth and tenth bits.
// - The offset-counter operation adds the accumulator to the current counter value.
// - Jump and invoke load the two top counter bits from the page select bits of the status register.
// - The page select bits pick one of four 1K-word pages, value 01 starting at 400h.
// - The low six pointer bits pick one of 64 data registers, and the whole pointer is a plain read/write register.
// - Returns leave the page select bits untouched.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"

module cps_core #(
    parameter int STACK_DEPTH = 8,
    parameter int DATA_REGS   = 64
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [11:0]       PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              COUNT_PIN_I,
    input  wire logic [12:0]       ROM_DATA_I,
    output cps_pkg::cps_pc_t       ROM_ADDR_O,
    output cps_pkg::cps_byte_t     TIMER_COUNT_O
);
    import cps_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // Pointer indexes 64 locations, the stack needs at least two entries
    if (DATA_REGS != 64 || STACK_DEPTH < 2 || STACK_DEPTH > 64) begin : g_bad_params
        $error("cps_core: unsupported DATA_REGS or STACK_DEPTH");
    end

    cps_pc_t              pc_r;
    cps_byte_t            timer_r;
    logic [1:0]           page_r;
    cps_byte_t            ram_sel_r;
    cps_byte_t            acc_r;
    logic [1:0]           tctrl_r;
    logic [12:0]          instr_r;
    cps_byte_t            data_mem_r [DATA_REGS];
    cps_pc_t              stack_r [STACK_DEPTH];
    logic [SP_W-1:0]      sp_r;
    logic [SP_W:0]        stack_cnt_r;
    logic                 ready_r;
    logic [31:0]          rdata_r;
    logic                 slverr_r;
    logic                 pin_s1_r;
    logic                 pin_s2_r;
    logic                 pin_s3_r;
    logic                 pin_lvl_r;

    logic                 access;
    logic                 done;
    logic                 wr_done;
    logic [9:0]           idx;
    logic                 aligned;
    logic                 mapped;
    logic                 op_go;
    cps_op_t              op;
    logic [9:0]           op_addr;
    logic                 pin_lvl_nxt;
    logic                 pin_edge;
    logic                 tick;
    cps_pc_t              pc_nxt;
    logic [SP_W-1:0]      top;

    // Bus decode
    assign access  = PSEL_I && PENABLE_I;
    assign done    = access && ready_r;
    assign wr_done = done && PWRITE_I && mapped;
    assign idx     = PADDR_I[11:2];
    assign aligned = (PADDR_I[1:0] == 2'h0);
    assign op      = cps_op_t'(PWDATA_I[`CPS_OP_CODE_MSB:`CPS_OP_CODE_LSB]);
    assign op_addr = PWDATA_I[`CPS_OP_ADDR_MSB:0];
    assign op_go   = wr_done && (idx == `CPS_IDX_OPERATION);
    // Wraps by hand so a depth that is no power of two never indexes past the end
    assign top     = (sp_r == '0) ? SP_W'(STACK_DEPTH - 1) : sp_r - SP_W'(1);

    // Index decode; unmapped or misaligned addresses answer with an error
    always_comb begin
        mapped = 1'b0;
        if (aligned) begin
            unique case (idx)
                `CPS_IDX_INDIRECT, `CPS_IDX_TIMER, `CPS_IDX_PC, `CPS_IDX_STATUS,
                `CPS_IDX_RAM_SEL, `CPS_IDX_ACC, `CPS_IDX_TMR_CTRL,
                `CPS_IDX_OPERATION, `CPS_IDX_INSTR, `CPS_IDX_STACK_CNT: begin
                    mapped = 1'b1;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    // One wait state: read data and ready are both registered
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= access && !ready_r;
        end
    end

    // Read mux, sampled in the wait cycle so the data stands with ready
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            rdata_r  <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (access && !ready_r) begin
            slverr_r <= !mapped;
            rdata_r  <= 32'h0000_0000;
            if (mapped && !PWRITE_I) begin
                unique case (idx)
                    `CPS_IDX_INDIRECT:  rdata_r[7:0] <= data_mem_r[ram_sel_r[`CPS_RAM_SEL_MSB:0]];
                    `CPS_IDX_TIMER:     rdata_r[7:0] <= timer_r;
                    `CPS_IDX_PC:        rdata_r[11:0] <= pc_r;
                    `CPS_IDX_STATUS:    rdata_r[`CPS_STATUS_PAGE_MSB:`CPS_STATUS_PAGE_LSB] <= page_r;
                    `CPS_IDX_RAM_SEL:   rdata_r[7:0] <= ram_sel_r;
                    `CPS_IDX_ACC:       rdata_r[7:0] <= acc_r;
                    `CPS_IDX_TMR_CTRL:  rdata_r[1:0] <= tctrl_r;
                    `CPS_IDX_INSTR:     rdata_r[12:0] <= instr_r;
                    `CPS_IDX_STACK_CNT: rdata_r[SP_W:0] <= stack_cnt_r;
                    default:            rdata_r <= 32'h0000_0000;
                endcase
            end
        end else begin
            slverr_r <= 1'b0;                                  // Error stands only with ready
        end
    end

    assign PRDATA_O  = rdata_r;
    assign PREADY_O  = ready_r;
    assign PSLVERR_O = slverr_r;

    // Plain software registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            ram_sel_r <= `CPS_RST_BYTE;
            page_r    <= `CPS_RST_PAGE;
            tctrl_r   <= `CPS_RST_TCTRL;
        end else if (wr_done) begin
            unique case (idx)
                `CPS_IDX_RAM_SEL:  ram_sel_r <= PWDATA_I[7:0];
                `CPS_IDX_STATUS:   page_r <= PWDATA_I[`CPS_STATUS_PAGE_MSB:`CPS_STATUS_PAGE_LSB];
                `CPS_IDX_TMR_CTRL: tctrl_r <= PWDATA_I[1:0];
                default: begin
                end
            endcase
        end
    end

    // Accumulator; exit-with-literal returns its literal here
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            acc_r <= `CPS_RST_BYTE;
        end else if (wr_done && idx == `CPS_IDX_ACC) begin
            acc_r <= PWDATA_I[7:0];
        end else if (op_go && op == CPS_OP_EXIT_WITH_LITERAL_OP) begin
            acc_r <= PWDATA_I[7:0];
        end
    end

    // Data registers behind the indirect port; the port itself holds nothing
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < DATA_REGS; i++) begin
                data_mem_r[i] <= `CPS_RST_BYTE;
            end
        end else if (wr_done && idx == `CPS_IDX_INDIRECT) begin
            data_mem_r[ram_sel_r[`CPS_RAM_SEL_MSB:0]] <= PWDATA_I[7:0];
        end
    end

    // Counter pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            pin_s1_r  <= 1'b0;
            pin_s2_r  <= 1'b0;
            pin_s3_r  <= 1'b0;
            pin_lvl_r <= 1'b0;
        end else begin
            pin_s1_r  <= COUNT_PIN_I;
            pin_s2_r  <= pin_s1_r;
            pin_s3_r  <= pin_s2_r;
            pin_lvl_r <= pin_lvl_nxt;
        end
    end

    assign pin_lvl_nxt = (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_lvl_r;
    // Edge bit low counts rising edges, high counts falling edges
    assign pin_edge = (pin_lvl_nxt != pin_lvl_r) && (pin_lvl_nxt != tctrl_r[`CPS_TCTRL_EDGE_BIT]);
    assign tick     = tctrl_r[`CPS_TCTRL_SRC_BIT] ? pin_edge : 1'b1;

    // Timer count; a software write in the same cycle wins over a count
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            timer_r <= `CPS_RST_BYTE;
        end else if (wr_done && idx == `CPS_IDX_TIMER) begin
            timer_r <= PWDATA_I[7:0];
        end else if (tick) begin
            timer_r <= timer_r + 8'h01;
        end
    end

    assign TIMER_COUNT_O = timer_r;

    // Next counter value for each operation
    always_comb begin
        pc_nxt = pc_r;
        if (op_go) begin
            unique case (op)
                CPS_OP_STEP:     pc_nxt = pc_r + 12'h001;
                CPS_OP_JUMP,
                CPS_OP_CALL:     pc_nxt = {page_r, op_addr};
                CPS_OP_RET,
                CPS_OP_EXIT_WITH_LITERAL_OP,
                CPS_OP_INTERRUPT_EXIT_OP:     pc_nxt = stack_r[top];
                CPS_OP_LOAD_ACC: pc_nxt = {page_r, pc_r[9:8], acc_r};
                CPS_OP_ADD_ACC:  pc_nxt = pc_r + {4'h0, acc_r};
            endcase
        end else if (wr_done && idx == `CPS_IDX_PC) begin
            pc_nxt = PWDATA_I[11:0];
        end
    end

    // Program counter and fetched code; the counter spans the 4K store
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            pc_r    <= `CPS_RST_PC;
            instr_r <= 13'h0000;
        end else begin
            pc_r <= pc_nxt;
            if (op_go) begin
                instr_r <= ROM_DATA_I;
            end
        end
    end

    assign ROM_ADDR_O = pc_r;

    // Return stack; a push past the depth overwrites the oldest entry
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            sp_r        <= '0;
            stack_cnt_r <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= `CPS_RST_PC;
            end
        end else if (op_go && op == CPS_OP_CALL) begin
            stack_r[sp_r] <= pc_r + 12'h001;
            sp_r          <= (32'(sp_r) == STACK_DEPTH - 1) ? '0 : sp_r + SP_W'(1);
            if (32'(stack_cnt_r) < STACK_DEPTH) begin
                stack_cnt_r <= stack_cnt_r + (SP_W+1)'(1);
            end
        end else if (op_go && (op == CPS_OP_RET || op == CPS_OP_EXIT_WITH_LITERAL_OP || op == CPS_OP_INTERRUPT_EXIT_OP)) begin
            sp_r <= top;
            if (stack_cnt_r != '0) begin
                stack_cnt_r <= stack_cnt_r - (SP_W+1)'(1);
            end
        end
    end

endmodule : cps_core

`default_nettype wire

//--- common/cps_defs.svh
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define CPS_IDX_INDIRECT   10'h000
`define CPS_IDX_TIMER      10'h001
`define CPS_IDX_PC         10'h002
`define CPS_IDX_STATUS     10'h003
`define CPS_IDX_RAM_SEL    10'h004
`define CPS_IDX_ACC        10'h010
`define CPS_IDX_TMR_CTRL   10'h011
`define CPS_IDX_OPERATION  10'h012
`define CPS_IDX_INSTR      10'h013
`define CPS_IDX_STACK_CNT  10'h014

// Field positions
`define CPS_STATUS_PAGE_LSB 5
`define CPS_STATUS_PAGE_MSB 6
`define CPS_TCTRL_SRC_BIT   0
`define CPS_TCTRL_EDGE_BIT  1
`define CPS_OP_CODE_LSB     12
`define CPS_OP_CODE_MSB     14
`define CPS_OP_ADDR_MSB     9
`define CPS_RAM_SEL_MSB     5

// Program space
`define CPS_PAGE_WORDS      1024
`define CPS_PROG_WORDS      4096
`define CPS_INSTR_BITS      13

// Reset values
`define CPS_RST_PC          12'h000
`define CPS_RST_BYTE        8'h00
`define CPS_RST_PAGE        2'h0
`define CPS_RST_TCTRL       2'h0

`endif

//--- common/cps_pkg.sv
package cps_pkg;

    // Program counter operations; the encoding is the order given here
    typedef enum logic [2:0] {
        CPS_OP_STEP,
        CPS_OP_JUMP,
        CPS_OP_CALL,
        CPS_OP_RET,
        CPS_OP_EXIT_WITH_LITERAL_OP,
        CPS_OP_INTERRUPT_EXIT_OP,
        CPS_OP_LOAD_ACC,
        CPS_OP_ADD_ACC
    } cps_op_t;

    typedef logic [11:0] cps_pc_t;
    typedef logic [7:0]  cps_byte_t;

endpackage : cps_pkg

//--- bench/cps_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cps_core_properties
    import cps_pkg::*;
(
    input wire logic           SYS_CLK_I,
    input wire logic           RST_N_I,
    input wire logic           PSEL_I,
    input wire logic           PENABLE_I,
    input wire logic           PWRITE_I,
    input wire logic [11:0]    PADDR_I,
    input wire logic [31:0]    PWDATA_I,
    input wire logic           PREADY_O,
    input wire logic           PSLVERR_O,
    input wire cps_pkg::cps_pc_t   ROM_ADDR_O,
    input wire cps_pkg::cps_byte_t TIMER_COUNT_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Completed writes, split by the register they hit
    logic xfer;
    logic tmr_wr;
    logic pc_wr;
    logic op_wr;
    assign xfer   = PSEL_I && PENABLE_I && PREADY_O;
    assign tmr_wr = xfer && PWRITE_I && (PADDR_I == 12'h004);
    assign pc_wr  = xfer && PWRITE_I && (PADDR_I == 12'h008);
    assign op_wr  = xfer && PWRITE_I && (PADDR_I == 12'h048);

    property p_rdy;
        PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I) ##1 !PREADY_O;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready outside access");
    property p_err;
        PSLVERR_O |-> PREADY_O;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    // Wrap-safe: difference is taken in eight bits
    property p_tmr_step;
        $past(RST_N_I) && !$past(tmr_wr) |-> 8'(TIMER_COUNT_O - $past(TIMER_COUNT_O)) <= 8'h01;
    endproperty
    a_tmr_step: assert property (p_tmr_step) else $error("timer jumped");
    property p_tmr_wr;
        tmr_wr |=> TIMER_COUNT_O == $past(PWDATA_I[7:0]);
    endproperty
    a_tmr_wr: assert property (p_tmr_wr) else $error("timer write lost");
    property p_pc_hold;
        $past(RST_N_I) && !$past(pc_wr || op_wr) |-> $stable(ROM_ADDR_O);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("counter moved");
    property p_pc_wr;
        pc_wr |=> ROM_ADDR_O == $past(PWDATA_I[11:0]);
    endproperty
    a_pc_wr: assert property (p_pc_wr) else $error("counter load lost");
    property p_step;
        op_wr && PWDATA_I[14:12] == 3'h0 |=> ROM_ADDR_O == $past(ROM_ADDR_O) + 12'h001;
    endproperty
    a_step: assert property (p_step) else $error("step wrong");
    property p_jump;
        op_wr && PWDATA_I[14:13] == 2'h0 && PWDATA_I[12] |=>
            ROM_ADDR_O[9:0] == $past(PWDATA_I[9:0]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump wrong");
    property p_ldacc;
        op_wr && PWDATA_I[14:12] == 3'h6 |=> ROM_ADDR_O[9:8] == $past(ROM_ADDR_O[9:8]);
    endproperty
    a_ldacc: assert property (p_ldacc) else $error("bits 9:8 changed");
endmodule : cps_core_properties

bind cps_core cps_core_properties u_props (
    .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .ROM_ADDR_O(ROM_ADDR_O), .TIMER_COUNT_O(TIMER_COUNT_O)
);
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cps_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pin = 1'b0;
    logic [12:0] rom = 13'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        perr;
    cps_pc_t     pc;
    cps_byte_t   tmr;
    int          n_mismatch = 0;
    int          tests_run = 0;

    cps_core uut (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(perr), .COUNT_PIN_I(pin),
        .ROM_DATA_I(rom), .ROM_ADDR_O(pc), .TIMER_COUNT_O(tmr)
    );

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; an idle edge after it keeps drives apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) n_mismatch++;
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask : rd

    // Operation word: code in 14:12, address field in 9:0
    task automatic op(input logic [2:0] c, input logic [9:0] f);
        wr(12'h048, {17'h0, c, 2'h0, f});
    endtask : op

    // Pulse is long enough for the pin synchroniser and filter
    task automatic pulse;
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse

    task automatic t_reset;
        repeat (8) @(posedge clk);
        chk(pc, 12'h000);
        chk(tmr, 8'h00);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask : t_reset

    task automatic t_timer;
        cps_byte_t t0;
        @(posedge clk);
        t0 = tmr;
        repeat (10) @(posedge clk);
        chk(tmr, 8'(t0 + 8'h0a));
        wr(12'h044, 32'h1);
        wr(12'h004, 32'h5a);
        rd(12'h004, 32'h5a);
        repeat (3) pulse;
        chk(tmr, 8'h5d);
        wr(12'h044, 32'h3);
        pulse;
        chk(tmr, 8'h5e);
        wr(12'h044, 32'h0);
    endtask : t_timer

    task automatic t_indirect;
        wr(12'h010, 32'h3f);
        wr(12'h000, 32'ha5);
        wr(12'h010, 32'h05);
        wr(12'h000, 32'h3c);
        wr(12'h010, 32'hff);
        rd(12'h000, 32'ha5);
        rd(12'h010, 32'hff);
        wr(12'h010, 32'h45);
        rd(12'h000, 32'h3c);
    endtask : t_indirect

    task automatic t_pc;
        wr(12'h00c, 32'h20);
        wr(12'h008, 32'h123);
        rom <= 13'h1abc;
        op(3'h0, 10'h000);
        rd(12'h008, 32'h124);
        rd(12'h04c, 32'h1abc);
        op(3'h1, 10'h2aa);
        chk(pc, 12'h6aa);
        op(3'h2, 10'h155);
        chk(pc, 12'h555);
        rd(12'h050, 32'h1);
        wr(12'h00c, 32'h60);
        op(3'h3, 10'h000);
        chk(pc, 12'h6ab);
        rd(12'h00c, 32'h60);
        wr(12'h040, 32'h80);
        op(3'h6, 10'h000);
        chk(pc, 12'he80);
        op(3'h7, 10'h000);
        chk(pc, 12'hf00);
        op(3'h2, 10'h100);
        chk(pc, 12'hd00);
        op(3'h4, 10'h077);
        chk(pc, 12'hf01);
        rd(12'h040, 32'h77);
        op(3'h2, 10'h001);
        op(3'h5, 10'h000);
        chk(pc, 12'hf02);
        rd(12'h050, 32'h0);
    endtask : t_pc

    task automatic t_errors;
        logic [31:0] q;
        logic        e;
        apb(1'b0, 12'h3fc, 32'h0, q, e);
        chk(e, 1'b1);
        chk(q, 32'h0);
        apb(1'b1, 12'h006, 32'hff, q, e);
        chk(e, 1'b1);
    endtask : t_errors

    task automatic tally_and_finish;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        t_reset;
        t_timer;
        t_indirect;
        t_pc;
        t_errors;
        tally_and_finish;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
